/* vips_core.sv */
/*
  Vectored interrupt controller with the paged program counter it steers.
  Assumes the sequencer drives vips_seq_cmd_s synchronously on mclk, timer
  underflows are one-cycle pulses on mclk, and the pin is asynchronous.
*/
// The AXI4-Lite register port and the register offsets are this design's own decisions.
// Functional notes
// RQ1 - PC counts up by instruction length
// RQ2 - Branch, call, return, table load target
// RQ3 - PC is page field plus 7-bit offset
// RQ4 - Offset 127 wraps to 0, page advances
// RQ5 - Pages of 128 ten-bit words
// RQ6 - Page 1 low region holds vectors
// RQ7 - Page 2 reachable by one-word call
// RQ8 - Table read returns low eight bits
// RQ9 - Take needs flag, enable, global enable
// RQ10 - Enable and disable instructions set global flag
// RQ11 - Accepting an interrupt clears global enable
// RQ12 - Enable bit 1 disables test-and-skip
// RQ13 - Activating condition sets request flag
// RQ14 - Flag clears on accept or skip
// RQ15 - Flags set regardless of enables, sticky
// RQ16 - Pending request taken once enabled
// RQ17 - Priority pin, timer 1, 2, 3
// RQ18 - Vectors at page 1 offsets 0,4,6,8
// RQ19 - Pin level change, timer underflow activate
// RQ20 - Enable bits in two control registers
// RQ21 - Enable bit 0 blocks, skip works
// RQ22 - Accept clears own flag, saves context
// RQ23 - Take 2 or 3 cycles after conditions
// RQ24 - Enable acts after one more instruction
`timescale 1ns/10ps
module vips_core (
  input wire logic mclk,
  input wire logic arst_n,
  input wire vips_pkg::vips_axi_req_s axi_req,
  output vips_pkg::vips_axi_rsp_s axi_rsp,
  input wire vips_pkg::vips_seq_cmd_s seq_cmd,
  input wire logic [vips_pkg::WORD_W-1:0] rom_word,
  input wire logic irq_pin,
  input wire logic timer_one_underflow,
  input wire logic timer_two_underflow,
  input wire logic timer_three_underflow,
  output logic [vips_pkg::PC_W-1:0] pc_out,
  output logic irq_take,
  output logic [vips_pkg::PC_W-1:0] irq_return_addr,
  output logic irq_context_save,
  output logic skip_next,
  output logic [vips_pkg::TABLE_W-1:0] table_data,
  output logic [vips_pkg::NSRC-1:0] request_flags,
  output logic global_irq_enable_flag
);
  // Program counter and its fields
  logic [vips_pkg::PC_W-1:0] pc_reg;
  logic [vips_pkg::PAGE_W-1:0] pc_page_field;
  logic [vips_pkg::OFS_W-1:0] pc_offset_field;
  // Control registers written by software
  logic [vips_pkg::EN_W-1:0] irq_enable_reg_a;
  logic [vips_pkg::EN_W-1:0] irq_enable_reg_b;
  // Request flags and global enable
  logic pin_event_request_flag;
  logic timer_one_request_flag;
  logic timer_two_request_flag;
  logic timer_three_request_flag;
  logic [vips_pkg::NSRC-1:0] flag_reg;
  logic gie_reg;
  logic ei_arm_reg; // Enable waits for one more instruction
  // Pin synchroniser and edge history
  logic pin_sync1_reg;
  logic pin_sync2_reg;
  logic pin_prev_reg;
  // Take sequencer
  vips_pkg::vips_take_e take_st_reg;
  logic [1:0] take_cnt_reg;
  // Output registers
  logic irq_take_reg;
  logic [vips_pkg::PC_W-1:0] ret_addr_reg;
  logic skip_reg;
  logic [vips_pkg::TABLE_W-1:0] table_reg;
  vips_pkg::vips_axi_rsp_s rsp_reg;
  // AXI capture
  logic aw_held_reg;
  logic w_held_reg;
  logic [vips_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  // Combinational terms
  logic [vips_pkg::NSRC-1:0] event_vec;
  logic [vips_pkg::NSRC-1:0] enable_vec;
  logic [vips_pkg::NSRC-1:0] ready_vec;
  logic [vips_pkg::NSRC-1:0] skip_clr;
  logic [vips_pkg::NSRC-1:0] take_clr;
  logic take_cond;
  logic take_now;
  logic [vips_pkg::OFS_W-1:0] take_vec;
  logic [vips_pkg::NSRC-1:0] take_sel;
  logic wr_fire;

  assign pc_page_field = pc_reg[vips_pkg::PC_W-1:vips_pkg::OFS_W]; // RQ3
  assign pc_offset_field = pc_reg[vips_pkg::OFS_W-1:0]; // RQ3
  assign pin_event_request_flag = flag_reg[vips_pkg::SRC_PIN];
  assign timer_one_request_flag = flag_reg[vips_pkg::SRC_T1];
  assign timer_two_request_flag = flag_reg[vips_pkg::SRC_T2];
  assign timer_three_request_flag = flag_reg[vips_pkg::SRC_T3];

  // Pin passes two flops before the edge detector looks at it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync1_reg <= 1'b0;
      pin_sync2_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_sync1_reg <= irq_pin;
      pin_sync2_reg <= pin_sync1_reg;
      pin_prev_reg <= pin_sync2_reg;
    end
  end

  // Activating events; either pin edge counts
  always_comb begin
    event_vec = '0;
    event_vec[vips_pkg::SRC_PIN] = pin_sync2_reg ^ pin_prev_reg; // RQ19
    event_vec[vips_pkg::SRC_T1] = timer_one_underflow; // RQ19
    event_vec[vips_pkg::SRC_T2] = timer_two_underflow;
    event_vec[vips_pkg::SRC_T3] = timer_three_underflow;
  end

  // Enable bits gathered from both control registers
  always_comb begin
    enable_vec = '0;
    enable_vec[vips_pkg::SRC_PIN] = irq_enable_reg_a[vips_pkg::EN_A_PIN]; // RQ20
    enable_vec[vips_pkg::SRC_T1] = irq_enable_reg_a[vips_pkg::EN_A_T1]; // RQ20
    enable_vec[vips_pkg::SRC_T2] = irq_enable_reg_a[vips_pkg::EN_A_T2]; // RQ20
    enable_vec[vips_pkg::SRC_T3] = irq_enable_reg_b[vips_pkg::EN_B_T3]; // RQ20
  end

  // Sources eligible for the vector mechanism
  assign ready_vec = flag_reg & enable_vec; // RQ9
  assign take_cond = gie_reg && (|ready_vec); // RQ9 RQ16

  // Fixed priority: lowest index wins
  always_comb begin
    take_sel = '0;
    take_vec = vips_pkg::VEC_T3;
    if (ready_vec[vips_pkg::SRC_PIN]) begin // RQ17
      take_sel[vips_pkg::SRC_PIN] = 1'b1;
      take_vec = vips_pkg::VEC_PIN; // RQ18
    end else if (ready_vec[vips_pkg::SRC_T1]) begin
      take_sel[vips_pkg::SRC_T1] = 1'b1;
      take_vec = vips_pkg::VEC_T1; // RQ18
    end else if (ready_vec[vips_pkg::SRC_T2]) begin
      take_sel[vips_pkg::SRC_T2] = 1'b1;
      take_vec = vips_pkg::VEC_T2; // RQ18
    end else if (ready_vec[vips_pkg::SRC_T3]) begin
      take_sel[vips_pkg::SRC_T3] = 1'b1;
      take_vec = vips_pkg::VEC_T3; // RQ18
    end
  end

  // Take fires when the latency count runs out with conditions still true
  assign take_now = (take_st_reg == vips_pkg::ST_WAIT) && (take_cnt_reg == '0) && take_cond;
  assign take_clr = take_now ? take_sel : '0; // RQ22

  // Skip works only while the enable bit is 0 and the flag is up
  assign skip_clr = seq_cmd.skip_on & ~enable_vec & flag_reg; // RQ12 RQ21

  // Latency counter: 2 cycles, 3 during a multi-cycle instruction
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      take_st_reg <= vips_pkg::ST_IDLE;
      take_cnt_reg <= '0;
    end else begin
      case (take_st_reg)
        vips_pkg::ST_IDLE: begin
          if (take_cond) begin
            take_st_reg <= vips_pkg::ST_WAIT;
            take_cnt_reg <= (seq_cmd.multi_cycle ? vips_pkg::LAT_LONG
                                                 : vips_pkg::LAT_SHORT) - vips_pkg::LAT_ONE; // RQ23
          end
        end
        vips_pkg::ST_WAIT: begin
          // Conditions withdrawn, e.g. disable or an enable bit cleared: abandon quietly
          if (!take_cond || take_now) begin
            take_st_reg <= vips_pkg::ST_IDLE;
          end else begin
            take_cnt_reg <= take_cnt_reg - vips_pkg::LAT_ONE; // RQ23
          end
        end
        default: begin
          take_st_reg <= vips_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Request flags; a new event beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < vips_pkg::NSRC; gi++) begin : g_flag
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          flag_reg[gi] <= 1'b0;
        end else if (event_vec[gi]) begin
          flag_reg[gi] <= 1'b1; // RQ13 RQ15
        end else if (take_clr[gi] || skip_clr[gi]) begin
          flag_reg[gi] <= 1'b0; // RQ14 RQ22
        end
      end
    end
  endgenerate

  // Global enable: disable is immediate, enable waits one instruction
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gie_reg <= 1'b0;
      ei_arm_reg <= 1'b0;
    end else if (take_now) begin
      gie_reg <= 1'b0; // RQ11
      ei_arm_reg <= 1'b0;
    end else if (seq_cmd.disable_irq_instr) begin
      gie_reg <= 1'b0; // RQ10
      ei_arm_reg <= 1'b0;
    end else if (seq_cmd.enable_irq_instr) begin
      ei_arm_reg <= 1'b1; // RQ24
    end else if (ei_arm_reg && seq_cmd.instr_done) begin
      gie_reg <= 1'b1; // RQ10 RQ24
      ei_arm_reg <= 1'b0;
    end
  end

  // Program counter; vector load beats every instruction update
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= vips_pkg::PC_RST;
    end else if (take_now) begin
      pc_reg <= {vips_pkg::VEC_PAGE, take_vec}; // RQ6 RQ18
    end else if (seq_cmd.branch_load) begin
      pc_reg <= seq_cmd.branch_target; // RQ2
    end else if (seq_cmd.page_two_call_instr) begin
      pc_reg <= {vips_pkg::CALL_PAGE, seq_cmd.call_offset}; // RQ7
    end else if (seq_cmd.instr_done) begin
      // Plain binary add: offset 127 carries into the page field
      pc_reg <= pc_reg + vips_pkg::PC_STEP; // RQ1 RQ4 RQ5
    end
  end

  // Take pulse, return address and context save strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_take_reg <= 1'b0;
      ret_addr_reg <= vips_pkg::PC_RST;
    end else begin
      irq_take_reg <= take_now; // RQ22
      if (take_now) begin
        ret_addr_reg <= pc_reg; // RQ22
      end
    end
  end

  // Skip result and table read data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      skip_reg <= 1'b0;
      table_reg <= '0;
    end else begin
      skip_reg <= |skip_clr; // RQ14
      if (seq_cmd.table_read_instr) begin
        table_reg <= rom_word[vips_pkg::TABLE_W-1:0]; // RQ8
      end
    end
  end

  // AXI write: address and data captured in either order
  assign wr_fire = aw_held_reg && w_held_reg && !rsp_reg.bvalid;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (axi_req.awvalid && rsp_reg.awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= axi_req.awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (axi_req.wvalid && rsp_reg.wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= axi_req.wdata;
        wstrb_reg <= axi_req.wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Control registers; only byte lane 0 carries bits
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable_reg_a <= vips_pkg::EN_RST;
      irq_enable_reg_b <= vips_pkg::EN_RST;
    end else if (wr_fire && wstrb_reg[0]) begin
      if (awaddr_reg == vips_pkg::ADDR_EN_A) begin
        irq_enable_reg_a <= wdata_reg[vips_pkg::EN_W-1:0]; // RQ20
      end else if (awaddr_reg == vips_pkg::ADDR_EN_B) begin
        irq_enable_reg_b <= wdata_reg[vips_pkg::EN_W-1:0]; // RQ20
      end
    end
  end

  // Bus responses; unmapped addresses answer SLVERR
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_reg <= '0;
    end else begin
      // Each ready only while its own channel holds nothing, so one write at a time
      rsp_reg.awready <= !aw_held_reg && !(axi_req.awvalid && rsp_reg.awready);
      rsp_reg.wready <= !w_held_reg && !(axi_req.wvalid && rsp_reg.wready);
      if (wr_fire) begin
        rsp_reg.bvalid <= 1'b1;
        rsp_reg.bresp <= (awaddr_reg == vips_pkg::ADDR_EN_A || awaddr_reg == vips_pkg::ADDR_EN_B
                          || awaddr_reg == vips_pkg::ADDR_STATUS || awaddr_reg == vips_pkg::ADDR_PC
                          || awaddr_reg == vips_pkg::ADDR_TABLE)
                         ? vips_pkg::RESP_OKAY : vips_pkg::RESP_SLVERR;
      end else if (axi_req.bready) begin
        rsp_reg.bvalid <= 1'b0;
      end
      // Read side: one outstanding read
      if (axi_req.arvalid && rsp_reg.arready) begin
        rsp_reg.arready <= 1'b0;
        rsp_reg.rvalid <= 1'b1;
        rsp_reg.rresp <= vips_pkg::RESP_OKAY;
        rsp_reg.rdata <= '0;
        case (axi_req.araddr)
          vips_pkg::ADDR_EN_A: rsp_reg.rdata[vips_pkg::EN_W-1:0] <= irq_enable_reg_a;
          vips_pkg::ADDR_EN_B: rsp_reg.rdata[vips_pkg::EN_W-1:0] <= irq_enable_reg_b;
          vips_pkg::ADDR_STATUS: rsp_reg.rdata[vips_pkg::NSRC+1:0] <= {ei_arm_reg, gie_reg,
                                                                      flag_reg};
          vips_pkg::ADDR_PC: rsp_reg.rdata[vips_pkg::PC_W-1:0] <= pc_reg;
          vips_pkg::ADDR_TABLE: rsp_reg.rdata[vips_pkg::TABLE_W-1:0] <= table_reg;
          default: rsp_reg.rresp <= vips_pkg::RESP_SLVERR;
        endcase
      end else if (rsp_reg.rvalid && axi_req.rready) begin
        rsp_reg.rvalid <= 1'b0;
        rsp_reg.arready <= 1'b1;
      end else if (!rsp_reg.rvalid) begin
        rsp_reg.arready <= 1'b1;
      end
    end
  end

  // All outputs straight from flops
  assign axi_rsp = rsp_reg;
  assign pc_out = pc_reg;
  assign irq_take = irq_take_reg;
  assign irq_return_addr = ret_addr_reg;
  assign irq_context_save = irq_take_reg; // RQ22
  assign skip_next = skip_reg;
  assign table_data = table_reg;
  assign request_flags = flag_reg;
  assign global_irq_enable_flag = gie_reg;

  // Checks
  property p_vector;
    @(posedge mclk) disable iff (!arst_n)
      take_now |=> (pc_reg[vips_pkg::PC_W-1:vips_pkg::OFS_W] == vips_pkg::VEC_PAGE);
  endproperty
  a_vector: assert property (p_vector) else $error("PC not in vector page"); // RQ18

  property p_gie_clear;
    @(posedge mclk) disable iff (!arst_n)
      take_now |=> !gie_reg ##1 irq_take_reg == 1'b0;
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("Global enable kept"); // RQ11

  property p_flag_set;
    @(posedge mclk) disable iff (!arst_n)
      timer_one_underflow |=> timer_one_request_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Timer 1 flag not set"); // RQ13

  property p_skip_clear;
    @(posedge mclk) disable iff (!arst_n)
      (skip_clr[vips_pkg::SRC_T2] && !timer_two_underflow) |=> !timer_two_request_flag && skip_reg;
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("Skip did not clear"); // RQ14

  property p_wrap;
    @(posedge mclk) disable iff (!arst_n)
      (seq_cmd.instr_done && !take_now && !seq_cmd.branch_load && !seq_cmd.page_two_call_instr
       && pc_reg[vips_pkg::OFS_W-1:0] == vips_pkg::OFS_LAST)
      |=> (pc_reg[vips_pkg::OFS_W-1:0] == '0)
          && (pc_reg[vips_pkg::PC_W-1:vips_pkg::OFS_W] == $past(pc_page_field) + 1'b1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Page wrap wrong"); // RQ4

  property p_latency;
    @(posedge mclk) disable iff (!arst_n)
      (take_st_reg == vips_pkg::ST_IDLE && take_cond && !seq_cmd.multi_cycle
       && !event_vec[vips_pkg::SRC_PIN])
      ##1 take_cond ##1 take_cond |-> take_now;
  endproperty
  a_latency: assert property (p_latency) else $error("Take not at second cycle"); // RQ23

  property p_ei_delay;
    @(posedge mclk) disable iff (!arst_n)
      (seq_cmd.enable_irq_instr && !gie_reg && !seq_cmd.disable_irq_instr) |=> !gie_reg;
  endproperty
  a_ei_delay: assert property (p_ei_delay) else $error("Enable acted at once"); // RQ24

  property p_needs_all;
    @(posedge mclk) disable iff (!arst_n)
      take_now |-> gie_reg && (|(flag_reg & enable_vec));
  endproperty
  a_needs_all: assert property (p_needs_all) else $error("Take without conditions"); // RQ9

  property p_priority;
    @(posedge mclk) disable iff (!arst_n)
      (take_now && ready_vec[vips_pkg::SRC_PIN])
      |=> pc_reg[vips_pkg::OFS_W-1:0] == vips_pkg::VEC_PIN;
  endproperty
  a_priority: assert property (p_priority) else $error("Pin not served first"); // RQ17

  property p_call;
    @(posedge mclk) disable iff (!arst_n)
      (seq_cmd.page_two_call_instr && !take_now && !seq_cmd.branch_load)
      |=> pc_reg[vips_pkg::PC_W-1:vips_pkg::OFS_W] == vips_pkg::CALL_PAGE;
  endproperty
  a_call: assert property (p_call) else $error("Call not into page 2"); // RQ7
endmodule // vips_core

/* vips_pkg.sv */
/*
  Constants, field layouts and carrier structs for the vectored interrupt
  and program counter sequencer.
  Assumes a single 100 MHz clock domain and an AXI4-Lite register master.
*/
package vips_pkg;
  // Program counter layout
  localparam int PC_W = 13; // Page plus offset
  localparam int OFS_W = 7; // In-page offset width
  localparam int PAGE_W = 6; // Page field width
  localparam logic [OFS_W-1:0] OFS_LAST = 7'h7f; // Last word of a page
  localparam logic [PC_W-1:0] PC_RST = 13'h0000; // Start address
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001; // One-word instruction
  localparam int PAGE_WORDS = 128; // Words per page
  localparam int WORD_W = 10; // Program word width
  localparam int TABLE_W = 8; // Data bits of a program word

  // Fixed pages and vector offsets
  localparam logic [PAGE_W-1:0] VEC_PAGE = 6'h01; // Vector page
  localparam logic [PAGE_W-1:0] CALL_PAGE = 6'h02; // Common subroutine page
  localparam logic [OFS_W-1:0] VEC_PIN = 7'h00;
  localparam logic [OFS_W-1:0] VEC_T1 = 7'h04;
  localparam logic [OFS_W-1:0] VEC_T2 = 7'h06;
  localparam logic [OFS_W-1:0] VEC_T3 = 7'h08;

  // Sources in priority order, index 0 highest
  localparam int NSRC = 4;
  localparam int SRC_PIN = 0;
  localparam int SRC_T1 = 1;
  localparam int SRC_T2 = 2;
  localparam int SRC_T3 = 3;

  // Enable bit positions in the two control registers
  localparam int EN_W = 4;
  localparam int EN_A_PIN = 0;
  localparam int EN_A_T1 = 2;
  localparam int EN_A_T2 = 3;
  localparam int EN_B_T3 = 0;
  localparam logic [EN_W-1:0] EN_RST = 4'h0;

  // Take latency in machine cycles
  localparam logic [1:0] LAT_SHORT = 2'h2;
  localparam logic [1:0] LAT_LONG = 2'h3;
  localparam logic [1:0] LAT_ONE = 2'h1;

  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_EN_A = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_EN_B = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PC = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_TABLE = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {ST_IDLE, ST_WAIT} vips_take_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } vips_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vips_axi_rsp_s;

  // One command word per machine cycle from the instruction sequencer
  typedef struct packed {
    logic instr_done; // An instruction finished this cycle
    logic multi_cycle; // A multi-cycle instruction is executing
    logic branch_load; // Branch, call, return: load target
    logic [PC_W-1:0] branch_target;
    logic page_two_call_instr; // One-word call into page 2
    logic [OFS_W-1:0] call_offset;
    logic table_read_instr; // Read low bits of rom_word
    logic enable_irq_instr;
    logic disable_irq_instr;
    logic [NSRC-1:0] skip_on; // Test-and-skip per source
  } vips_seq_cmd_s;
endpackage

/* vips_seq_model.sv */
/*
  Behavioural model of the instruction sequencer and the event sources.
  Assumes the bench calls its tasks and that mclk is the core clock.
*/
`timescale 1ns/10ps
module vips_seq_model (
  input wire logic mclk,
  output vips_pkg::vips_seq_cmd_s seq_cmd,
  output logic [vips_pkg::WORD_W-1:0] rom_word,
  output logic irq_pin,
  output logic [2:0] tmr_uf
);
  // Quiet until the bench asks for something
  initial begin
    seq_cmd = '0;
    rom_word = 10'h000;
    irq_pin = 1'b0;
    tmr_uf = 3'h0;
  end
  // One command word for one machine cycle
  task automatic issue(input vips_pkg::vips_seq_cmd_s c, input logic [9:0] w);
    @(posedge mclk);
    seq_cmd <= c;
    rom_word <= w;
    @(posedge mclk);
    // Multi-cycle is a level: it stays until the next command word
    seq_cmd <= '{multi_cycle:c.multi_cycle, default:'0};
    rom_word <= ~w; // Word not held after use
  endtask
  // Bit 0 toggles the pin, bits 3:1 pulse the timers
  task automatic events(input logic [3:0] m);
    @(posedge mclk);
    irq_pin <= irq_pin ^ m[0];
    tmr_uf <= m[3:1];
    @(posedge mclk);
    tmr_uf <= 3'h0;
  endtask
endmodule // vips_seq_model

/* vips_tb.sv */
/*
  Self-checking bench for the interrupt and program counter block.
  Assumes vips_seq_model drives the sequencer side; AXI4-Lite from here.
*/
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  vips_pkg::vips_axi_req_s req = '0; // Bus master side
  vips_pkg::vips_axi_rsp_s rsp;
  vips_pkg::vips_seq_cmd_s seq_cmd;
  logic [9:0] rom_word;
  logic irq_pin;
  logic [2:0] tmr_uf;
  logic [12:0] pc_out;
  logic irq_take;
  logic ctx_save;
  logic skip_next;
  logic gie;
  logic [7:0] table_data;
  logic [3:0] flags;
  logic [31:0] rd; // Last read data
  logic [1:0] rs; // Last response code
  logic [12:0] ret_addr; // Return address shown at a take
  logic [12:0] ret = 13'h0106; // PC expected at the next take
  logic [6:0] vec [4] = '{vips_pkg::VEC_PIN, vips_pkg::VEC_T1, vips_pkg::VEC_T2, vips_pkg::VEC_T3};
  int err_count = 0;
  int total_checks = 0;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  vips_seq_model u_seq (.mclk(mclk), .seq_cmd(seq_cmd), .rom_word(rom_word),
    .irq_pin(irq_pin), .tmr_uf(tmr_uf));
  vips_core dut (.mclk(mclk), .arst_n(arst_n), .axi_req(req), .axi_rsp(rsp),
    .seq_cmd(seq_cmd), .rom_word(rom_word), .irq_pin(irq_pin),
    .timer_one_underflow(tmr_uf[0]), .timer_two_underflow(tmr_uf[1]),
    .timer_three_underflow(tmr_uf[2]), .pc_out(pc_out), .irq_take(irq_take),
    .irq_return_addr(ret_addr), .irq_context_save(ctx_save), .skip_next(skip_next),
    .table_data(table_data), .request_flags(flags), .global_irq_enable_flag(gie));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, held until each is taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:d, wstrb:4'hf, bready:1'b1, default:'0};
    forever begin
      @(posedge mclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    rs = rsp.bresp;
    req <= '0;
  endtask
  // Read: rready held until the answer is sampled
  task automatic axr(input logic [7:0] a);
    @(posedge mclk);
    req <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
    forever begin
      @(posedge mclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    rd = rsp.rdata;
    rs = rsp.rresp;
    req <= '0;
  endtask
  // Sequencer command, then let the sampling edge settle
  task automatic go(input vips_pkg::vips_seq_cmd_s x, input logic [9:0] w);
    u_seq.issue(x, w);
    #1;
  endtask
  // Enable, one instruction, then wait bounded for the take
  task automatic take(input logic [12:0] exp_pc, input logic [3:0] exp_fl, input logic mc,
    input logic [12:0] exp_ret);
    int n;
    go('{enable_irq_instr:1'b1, default:'0}, 10'h000);
    chk(gie, 0);
    // Multi-cycle level stands in the cycle the conditions come true
    go('{instr_done:1'b1, multi_cycle:mc, default:'0}, 10'h000);
    n = 0;
    while (irq_take !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n, (mc ? vips_pkg::LAT_LONG : vips_pkg::LAT_SHORT) + 32'h1);
    chk(irq_take, 1);
    chk(pc_out, exp_pc);
    chk(gie, 0);
    chk(flags, exp_fl);
    chk(ctx_save, 1);
    chk(ret_addr, exp_ret);
  endtask
  // Counts, verdict, end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    // Reset values and refused access
    chk(pc_out, 0);
    axr(vips_pkg::ADDR_EN_A);
    chk(rd, 0);
    axr(vips_pkg::ADDR_STATUS);
    chk(rd, 0);
    axw(8'h20, 32'h0000000f);
    chk(rs, vips_pkg::RESP_SLVERR);
    axr(8'h20);
    chk(rs, vips_pkg::RESP_SLVERR);
    $display("test regs done");
    // Branch, page wrap, page two call, table read
    go('{branch_load:1'b1, branch_target:13'h007f, default:'0}, 10'h000);
    chk(pc_out, 13'h007f);
    go('{instr_done:1'b1, default:'0}, 10'h000);
    chk(pc_out, 13'h0080);
    go('{page_two_call_instr:1'b1, call_offset:7'h05, default:'0}, 10'h000);
    chk(pc_out, 13'h0105);
    go('{table_read_instr:1'b1, default:'0}, 10'h3a5);
    chk(table_data, 8'ha5);
    $display("test pc done");
    // Flags are sticky with everything disabled; skip clears only when allowed
    u_seq.events(4'hf);
    repeat (6) @(posedge mclk);
    #1;
    chk(flags, 4'hf);
    go('{skip_on:4'h4, default:'0}, 10'h000);
    chk(skip_next, 1);
    chk(flags, 4'hb);
    axw(vips_pkg::ADDR_EN_A, 32'h0000000d);
    axw(vips_pkg::ADDR_EN_B, 32'h00000001);
    axr(vips_pkg::ADDR_EN_A);
    chk(rd, 32'h0000000d);
    go('{skip_on:4'h2, default:'0}, 10'h000);
    chk(skip_next, 0);
    chk(flags, 4'hb);
    u_seq.events(4'h4);
    repeat (2) @(posedge mclk);
    #1;
    chk(flags, 4'hf);
    $display("test flags done");
    // All pending: one take per enable, in priority order
    for (int i = 0; i < 4; i++) begin
      take({vips_pkg::VEC_PAGE, vec[i]}, 4'he << i, 1'b0, ret);
      ret = {vips_pkg::VEC_PAGE, vec[i]} + 13'h0001;
    end
    $display("test priority done");
    // Disable clears the global enable; long latency during multi-cycle
    go('{enable_irq_instr:1'b1, default:'0}, 10'h000);
    go('{instr_done:1'b1, default:'0}, 10'h000);
    chk(gie, 1);
    go('{disable_irq_instr:1'b1, default:'0}, 10'h000);
    chk(gie, 0);
    u_seq.events(4'h8);
    repeat (4) @(posedge mclk);
    #1;
    chk(flags, 4'h8);
    chk(irq_take, 0);
    take({vips_pkg::VEC_PAGE, vips_pkg::VEC_T3}, 4'h0, 1'b1, ret + 13'h0001);
    $display("test latency done");
    finish_test();
  end
endmodule // tb
